// >>> hdl/audio_cmd_defs.svh
// Purpose: offsets, field positions, reset values, opcodes and timing counts
// Assumes: byte addresses on a 32-bit register bus, one word per register
// Notes: included by the package only; the serial port, the decoder and the bench import audio_cmd_pkg
`ifndef AUDIO_CMD_DEFS_SVH
`define AUDIO_CMD_DEFS_SVH

// opcodes
`define OP_PROMPT 8'ha6
`define OP_PROMPT_REG 8'hae
`define OP_LOOP 8'ha4
`define OP_LOOP_REG 8'hb2
`define OP_MACRO 8'hb0
`define OP_MACRO_REG 8'hbc
`define OP_SILENCE 8'ha8
`define OP_STOP 8'h2a

// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IDX_BASE 8'h10

// field layout and reset values
`define CHSEL_W 2
`define CHSEL_ALL 2'h3
`define CHSEL_RESET 2'h0
`define IDX_REGS 4
`define IDX_SEL_W 2
`define IDX_RESET 16'h0000
`define CHANNELS 3

// timing
`define MCLK_HZ 20000000
`define PATH_RATE_HZ 32000
`define SIL_UNIT_MS 32
`define SIL_UNIT_CYCLES ((`SIL_UNIT_MS * `MCLK_HZ) / 1000)
`define SIL_CNT_W 20

`endif

// >>> hdl/audio_cmd_pkg.sv
// Purpose: types shared by the command decoder and its serial byte port
// Assumes: constants come from audio_cmd_defs.svh
// Notes: the serial port keeps its whole state in spi_state_t; the decoder keeps opcode, reset sync and silence helpers outside core_state_t
package audio_cmd_pkg;
	`include "audio_cmd_defs.svh"

	typedef enum logic [1:0] {KIND_PROMPT, KIND_MACRO, KIND_SILENCE} cmd_kind_t;
	typedef enum logic [1:0] {DEC_IDLE, DEC_ARGS, DEC_SKIP} dec_state_t;

	typedef struct packed {
		logic sclkS1, sclkS2, sclkD;
		logic csS1, csS2, csD;
		logic mosiS1, mosiS2;
		logic [2:0] bitCnt;
		logic [7:0] rxSh;
		logic [7:0] txSh;
		logic miso, misoOe;
		logic rxValid;
		logic [7:0] rxData;
		logic frameEnd;
	} spi_state_t;

	typedef struct packed {
		dec_state_t st;
		logic [2:0] need;
		logic [31:0] args;
		logic [`CHSEL_W-1:0] chSel;
		logic [`IDX_REGS-1:0][15:0] idxRegs;
		logic bufValid;
		cmd_kind_t bufKind;
		logic [15:0] bufIdx, bufLoop;
		logic [1:0] bufCh;
		logic [`CHANNELS-1:0] busy, running;
		logic silOn;
		logic [1:0] silCh;
		logic [7:0] silLeft;
		logic [`SIL_CNT_W-1:0] silCyc;
		logic playValid;
		logic finPulse, errPulse, stopPulse;
		logic [`CHANNELS-1:0] stopMask;
		logic waitReq;
		logic [31:0] rdData;
	} core_state_t;
endpackage

// >>> hdl/spi_byte_if.sv
// Purpose: byte-level link between the serial port and the command decoder
// Assumes: both ends on mclk
// Notes: rxValid and frameEnd are one-cycle pulses
`timescale 1ns/100ps
interface spi_byte_if;
	logic rxValid;
	logic [7:0] rxData;
	logic frameEnd;
	logic [7:0] txStatus;
	modport port (output rxValid, output rxData, output frameEnd, input txStatus);
	modport user (input rxValid, input rxData, input frameEnd, output txStatus);
endinterface

// >>> hdl/spi_byte_port.sv
// Purpose: serial slave, mode 0, msb first, status byte shifted out on every byte
// Assumes: sclk at most mclk/8, pins asynchronous to mclk
// Notes: pins pass two flip-flops before any edge logic looks at them
`timescale 1ns/100ps
module spi_byte_port
	import audio_cmd_pkg::*;
(
	// clock and control
	input wire logic mclk,
	input wire logic rstN,
	input wire logic clkEn,
	// pins
	input wire logic spiSclk,
	input wire logic spiCsB,
	input wire logic spiMosi,
	output logic spiMiso,
	output logic spiMisoOe,
	// bytes
	spi_byte_if.port bytes
);
	spi_state_t s, n;
	logic rise, fall, csFall, csRise;

	assign rise = s.sclkS2 && !s.sclkD && !s.csS2;
	assign fall = !s.sclkS2 && s.sclkD && !s.csS2;
	assign csFall = !s.csS2 && s.csD;
	assign csRise = s.csS2 && !s.csD;

	always_comb begin
		n = s;
		n.sclkS1 = spiSclk;
		n.sclkS2 = s.sclkS1;
		n.sclkD = s.sclkS2;
		n.csS1 = spiCsB;
		n.csS2 = s.csS1;
		n.csD = s.csS2;
		n.mosiS1 = spiMosi;
		n.mosiS2 = s.mosiS1;
		n.rxValid = 1'b0;
		n.frameEnd = csRise;
		n.misoOe = !s.csS2;
		if (csFall) begin
			// first status byte must sit on the pin before the first rising edge
			n.bitCnt = 3'h0;
			n.txSh = bytes.txStatus;
			n.miso = bytes.txStatus[7];
		end else if (rise) begin
			n.rxSh = {s.rxSh[6:0], s.mosiS2};
			n.bitCnt = s.bitCnt + 3'h1;
			if (s.bitCnt == 3'h7) begin
				n.rxValid = 1'b1;
				n.rxData = {s.rxSh[6:0], s.mosiS2};
			end
		end else if (fall) begin
			if (s.bitCnt == 3'h0) begin
				n.txSh = bytes.txStatus;
				n.miso = bytes.txStatus[7];
			end else begin
				n.txSh = {s.txSh[6:0], 1'b0};
				n.miso = s.txSh[6];
			end
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			s <= '{sclkS1: 1'b0, sclkS2: 1'b0, sclkD: 1'b0, csS1: 1'b1, csS2: 1'b1, csD: 1'b1,
				default: '0};
		end else if (clkEn) begin
			s <= n;
		end
	end

	assign bytes.rxValid = s.rxValid;
	assign bytes.rxData = s.rxData;
	assign bytes.frameEnd = s.frameEnd;
	assign spiMiso = s.miso;
	assign spiMisoOe = s.misoOe;
endmodule

// >>> hdl/audio_play_command_decoder.sv
// Purpose: decodes and runs the audio play, macro, silence and stop commands
// Assumes: playback engine and core status on mclk; serial pins asynchronous
// Notes: one-entry command buffer; silence is timed here, prompts and macros by the engine
`timescale 1ns/100ps
module audio_play_command_decoder
	import audio_cmd_pkg::*;
#(
	parameter logic [`SIL_CNT_W-1:0] SIL_UNIT_CYCLES = `SIL_CNT_W'(`SIL_UNIT_CYCLES)
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clkEn,
	// register bus
	input wire logic [7:0] avAddress,
	input wire logic avRead,
	input wire logic avWrite,
	input wire logic [31:0] avWriteData,
	output logic [31:0] avReadData,
	output logic avWaitrequest,
	// serial pins
	input wire logic spiSclk,
	input wire logic spiCsB,
	input wire logic spiMosi,
	output logic spiMiso,
	output logic spiMisoOe,
	// core status
	input wire logic poweredDownFlag,
	input wire logic memoryPathBusyFlag,
	input wire logic intLine,
	// playback engine
	output logic playValid,
	output cmd_kind_t playKind,
	output logic [15:0] playIndex,
	output logic [15:0] playLoops,
	output logic [1:0] playChan,
	input wire logic playTake,
	input wire logic [`CHANNELS-1:0] playDone,
	output logic stopPulse,
	output logic [`CHANNELS-1:0] stopMask,
	// events to the interrupt block
	output logic commandFinishedIrq,
	output logic commandErrorIrq
);
	////////////////////////////////////////////////////////////////////////////
	logic rstMeta, rstN;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN <= rstMeta;
		end
	end

	spi_byte_if sp ();

	spi_byte_port u_port (
		.mclk(mclk),
		.rstN(rstN),
		.clkEn(clkEn),
		.spiSclk(spiSclk),
		.spiCsB(spiCsB),
		.spiMosi(spiMosi),
		.spiMiso(spiMiso),
		.spiMisoOe(spiMisoOe),
		.bytes(sp.port)
	);

	////////////////////////////////////////////////////////////////////////////
	core_state_t s, n;
	logic [7:0] statusByte;
	logic [31:0] argsNow, rdMux;
	logic [`CHANNELS-1:0] chMask, silMask;
	logic cmdDone, selAll, accept, stopHit, stopActive, flushed;
	logic [`IDX_SEL_W-1:0] regSel;
	logic [7:0] opcode;
	logic regFetch, loopRegFetch, loopFetch;

	assign regFetch = opcode == `OP_PROMPT_REG || opcode == `OP_MACRO_REG;
	assign loopRegFetch = opcode == `OP_LOOP_REG;
	assign loopFetch = opcode == `OP_LOOP;

	// pd, ready, int, 0, ch2..ch0 busy, memory busy
	assign statusByte = {poweredDownFlag, !s.bufValid, intLine, 1'b0, s.busy, memoryPathBusyFlag};
	assign sp.txStatus = statusByte;
	assign argsNow = {s.args[23:0], sp.rxData};
	assign selAll = s.chSel == `CHSEL_ALL;
	assign chMask = selAll ? {`CHANNELS{1'b1}} : `CHANNELS'(3'h1 << s.chSel);
	assign silMask = s.silOn ? `CHANNELS'(3'h1 << s.silCh) : '0;
	assign cmdDone = sp.rxValid && s.st == DEC_ARGS && s.need == 3'h1;
	// only the target channel is looked at; others are don't care
	assign accept = !poweredDownFlag && !s.bufValid && (s.busy & chMask) == '0 && !memoryPathBusyFlag;
	assign stopHit = sp.rxValid && s.st == DEC_IDLE && sp.rxData == `OP_STOP;
	// erase runs on the memory path, which stop never touches
	assign stopActive = s.bufValid || ((s.running | silMask) & chMask) != '0;
	assign flushed = s.bufValid && !(s.playValid && playTake);
	assign regSel = argsNow[`IDX_SEL_W-1:0];

	always_comb begin
		rdMux = 32'h0;
		if (avAddress == `REG_CTRL) begin
			rdMux[`CHSEL_W-1:0] = s.chSel;
		end else if (avAddress == `REG_STATUS) begin
			rdMux[7:0] = statusByte;
		end
		for (int i = 0; i < `IDX_REGS; i++) begin
			if (avAddress == `REG_IDX_BASE + 8'(4 * i)) begin
				rdMux[15:0] = s.idxRegs[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = s;
		n.finPulse = 1'b0;
		n.errPulse = 1'b0;
		n.stopPulse = 1'b0;
		n.stopMask = '0;

		// bus slave: one wait cycle, then the answer
		n.waitReq = !((avRead || avWrite) && s.waitReq);
		if (avRead && s.waitReq) begin
			n.rdData = rdMux;
		end
		if (avWrite && !s.waitReq) begin
			if (avAddress == `REG_CTRL) begin
				n.chSel = avWriteData[`CHSEL_W-1:0];
			end
			for (int i = 0; i < `IDX_REGS; i++) begin
				if (avAddress == `REG_IDX_BASE + 8'(4 * i)) begin
					n.idxRegs[i] = avWriteData[15:0];
				end
			end
		end

		// hand the buffered command to the engine or the silence timer
		if (s.playValid && playTake) begin
			n.playValid = 1'b0;
			n.bufValid = 1'b0;
			n.running[s.bufCh] = 1'b1;
		end else if (s.bufValid && !s.playValid) begin
			if (s.bufKind == KIND_SILENCE) begin
				if (!s.silOn) begin
					n.silOn = 1'b1;
					n.silCh = s.bufCh;
					n.silLeft = s.bufLoop[7:0];
					n.silCyc = '0;
					n.bufValid = 1'b0;
				end
			end else begin
				n.playValid = 1'b1;
			end
		end

		// silence counted in whole units of SIL_UNIT_CYCLES mclk cycles, 32 ms by default
		if (s.silOn) begin
			if (s.silLeft == 8'h0) begin
				n.silOn = 1'b0;
				n.busy[s.silCh] = 1'b0;
				n.finPulse = 1'b1;
			end else if (s.silCyc == SIL_UNIT_CYCLES - 1'b1) begin
				n.silCyc = '0;
				n.silLeft = s.silLeft - 8'h1;
			end else begin
				n.silCyc = s.silCyc + 1'b1;
			end
		end

		for (int c = 0; c < `CHANNELS; c++) begin
			if (playDone[c] && s.running[c]) begin
				n.running[c] = 1'b0;
				n.busy[c] = 1'b0;
				n.finPulse = 1'b1;
			end
		end

		// decoder
		if (sp.frameEnd) begin
			n.st = DEC_IDLE;
		end else if (sp.rxValid) begin
			case (s.st)
				DEC_IDLE: begin
					n.st = DEC_ARGS;
					n.args = '0;
					case (sp.rxData)
						`OP_PROMPT: n.need = 3'h2;
						`OP_PROMPT_REG: n.need = 3'h1;
						`OP_LOOP: n.need = 3'h4;
						`OP_LOOP_REG: n.need = 3'h3;
						`OP_MACRO: n.need = 3'h2;
						`OP_MACRO_REG: n.need = 3'h1;
						`OP_SILENCE: n.need = 3'h1;
						default: n.st = DEC_SKIP;
					endcase
					n.bufKind = s.bufValid ? s.bufKind : KIND_PROMPT;
					if (sp.rxData == `OP_MACRO || sp.rxData == `OP_MACRO_REG) begin
						n.args[31:24] = 8'h1;
					end else if (sp.rxData == `OP_SILENCE) begin
						n.args[31:24] = 8'h2;
					end
					n.need = n.st == DEC_ARGS ? n.need : 3'h0;
					if (sp.rxData == `OP_STOP && stopActive) begin
						// queued work is dropped; a running prompt or macro ends through the engine, a running silence ends here
						if (flushed) begin
							n.busy[s.bufCh] = 1'b0;
						end
						n.bufValid = 1'b0;
						n.playValid = 1'b0;
						n.stopMask = chMask & n.running;
						n.stopPulse = (chMask & n.running) != '0;
						if (s.silOn && chMask[s.silCh]) begin
							n.silOn = 1'b0;
							n.busy[s.silCh] = 1'b0;
							n.finPulse = 1'b1;
						end
					end
				end
				DEC_ARGS: begin
					n.need = s.need - 3'h1;
					n.args = {s.args[31:24], argsNow[23:0]};
					if (s.need == 3'h3) begin
						n.args[31:24] = s.args[31:24];
					end
				end
				DEC_SKIP: n.st = DEC_SKIP;
				default: n.st = DEC_IDLE;
			endcase
		end

		// complete command: decode per stored opcode and the kind tag kept in args[31:24]
		if (cmdDone && !selAll) begin
			if (accept) begin
				n.bufValid = 1'b1;
				n.bufCh = s.chSel;
				n.busy[s.chSel] = 1'b1;
				n.bufLoop = 16'h1;
				n.bufKind = KIND_PROMPT;
				case (s.args[26:24])
					3'h1: n.bufKind = KIND_MACRO;
					3'h2: n.bufKind = KIND_SILENCE;
					default: n.bufKind = KIND_PROMPT;
				endcase
				n.bufIdx = argsNow[15:0];
				if (s.args[26:24] == 3'h2) begin
					n.bufLoop = {8'h0, argsNow[7:0]};
					n.bufIdx = 16'h0;
				end
				if (regFetch) begin
					n.bufIdx = s.idxRegs[regSel];
				end
				if (loopRegFetch) begin
					n.bufIdx = s.idxRegs[argsNow[16 +: `IDX_SEL_W]];
					n.bufLoop = argsNow[15:0];
				end
				if (loopFetch) begin
					n.bufIdx = argsNow[31:16];
					n.bufLoop = argsNow[15:0];
				end
			end else begin
				n.errPulse = 1'b1;
			end
		end
		// bytes after a complete command, ignored or not, wait for the frame end
		if (cmdDone) begin
			n.st = DEC_SKIP;
		end
	end

	// the opcode is kept so that the argument layout is known at the last byte

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			opcode <= 8'h0;
		end else if (clkEn && sp.rxValid && s.st == DEC_IDLE) begin
			opcode <= sp.rxData;
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			s <= '{st: DEC_IDLE, chSel: `CHSEL_RESET, bufKind: KIND_PROMPT, waitReq: 1'b1, default: '0};
		end else if (clkEn) begin
			s <= n;
		end
	end

	assign avReadData = s.rdData;
	assign avWaitrequest = s.waitReq;
	assign playValid = s.playValid;
	assign playKind = s.bufKind;
	assign playIndex = s.bufIdx;
	assign playLoops = s.bufLoop;
	assign playChan = s.bufCh;
	assign stopPulse = s.stopPulse;
	assign stopMask = s.stopMask;
	assign commandFinishedIrq = s.finPulse;
	assign commandErrorIrq = s.errPulse;

	////////////////////////////////////////////////////////////////////////////
	// helper: cycles of silence actually counted against the requested length
	logic [31:0] silRun;
	logic [7:0] silLen;
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			silRun <= 32'h0;
			silLen <= 8'h0;
		end else if (clkEn) begin
			if (!s.silOn && n.silOn) begin
				silRun <= 32'h0;
				silLen <= n.silLeft;
			end else if (s.silOn && s.silLeft != 8'h0) begin
				silRun <= silRun + 32'h1;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstN || !clkEn);

	sequence lastByte_s; cmdDone && !selAll; endsequence
	sequence stopIdle_s; stopHit && !stopActive; endsequence

	reject_err_a: assert property (lastByte_s and !accept |=> s.errPulse && (!s.bufValid || $past(s.bufValid)))
		else $error("rejected command gave no error");
	accept_buf_a: assert property (lastByte_s and accept |=> s.bufValid && !statusByte[6] && !s.errPulse)
		else $error("accepted command not buffered");
	short_frame_a: assert property (s.st == DEC_ARGS && sp.frameEnd |=> !s.errPulse && s.st == DEC_IDLE)
		else $error("short frame changed state");
	sel_all_a: assert property (cmdDone && selAll |=> !s.errPulse && $stable(s.bufValid))
		else $error("command not ignored with select 3");
	stop_flush_a: assert property (stopHit && stopActive |=> !s.bufValid && !s.playValid)
		else $error("stop left the buffer full");
	stop_idle_a: assert property (stopIdle_s |=> !s.stopPulse && !s.finPulse && !s.bufValid)
		else $error("stop with nothing active changed state");
	stop_all_a: assert property (stopHit && selAll && playDone == '0 && !(s.playValid && playTake) |=>
		s.stopMask == $past(s.running))
		else $error("stop did not reach all channels");
	done_fin_a: assert property (playDone[0] && s.running[0] |=> s.finPulse && !s.busy[0])
		else $error("finish missing after playback");
	sil_len_a: assert property (s.silOn && s.silLeft == 8'h0 |-> silRun == silLen * SIL_UNIT_CYCLES)
		else $error("silence length wrong");
	sil_fin_a: assert property (s.silOn && s.silLeft == 8'h0 |=> s.finPulse && !s.silOn)
		else $error("silence end gave no finish");
	bus_wait_a: assert property ((avRead || avWrite) && s.waitReq |=> !s.waitReq ##1 s.waitReq)
		else $error("bus answer not after one wait cycle");
endmodule

// >>> verif/spi_host_model.sv
// Purpose: host controller model, serial master in mode 0
// Assumes: half bit period of 5 mclk cycles, pins driven on rising mclk
// Notes: sclk stands still low between frames
`timescale 1ns/100ps
module spi_host_model (
	// clock
	input wire logic mclk,
	// serial pins
	output logic spiSclk,
	output logic spiCsB,
	output logic spiMosi,
	input wire logic spiMiso
);
	localparam int HALF = 5;

	initial begin
		spiSclk = 1'b0;
		spiCsB = 1'b1;
		spiMosi = 1'b0;
	end

	// bytes leave from the top of data, msb first, so 16-bit fields go high byte first
	task automatic sendFrame(input logic [39:0] data, input int nBytes, output logic [7:0] firstStatus);
		firstStatus = 8'h00;
		@(posedge mclk);
		spiCsB <= 1'b0;
		for (int i = 0; i < nBytes * 8; i++) begin
			spiMosi <= data[39-i];
			repeat (HALF) @(posedge mclk);
			spiSclk <= 1'b1;
			if (i < 8)
				firstStatus[7-i] = spiMiso;
			repeat (HALF) @(posedge mclk);
			spiSclk <= 1'b0;
		end
		repeat (HALF) @(posedge mclk);
		spiCsB <= 1'b1;
		// released line must not keep showing the last bit
		spiMosi <= ~spiMosi;
		repeat (2 * HALF) @(posedge mclk);
	endtask
endmodule

// >>> verif/test_audio_play_command_decoder.sv
// Purpose: self-checking bench for the play command decoder
// Assumes: silence unit shortened to 64 cycles
// Notes: bench acts as playback engine; results matched through a note queue
`timescale 1ns/100ps
module test_audio_play_command_decoder
	import audio_cmd_pkg::*;
;
	localparam logic [19:0] UNIT = 20'h40;
	localparam logic [39:0] FIN = 40'h1000000000;
	localparam logic [39:0] ERR = 40'h2000000000;
	logic mclk, rst_b, clkEn, avRead, avWrite, avWaitrequest;
	logic [7:0] avAddress, st, rb;
	logic [31:0] avWriteData, avReadData, q;
	logic spiSclk, spiCsB, spiMosi, spiMiso, spiMisoOe;
	logic poweredDownFlag, memoryPathBusyFlag, intLine;
	logic playValid, playTake, stopPulse, commandFinishedIrq, commandErrorIrq;
	cmd_kind_t playKind;
	logic [15:0] playIndex, playLoops, ix, lp;
	logic [1:0] playChan, ch;
	logic [2:0] playDone, stopMask, stopSeen;
	logic [15:0] idxVal [4];
	logic [7:0] ops [6] = '{8'ha6, 8'hae, 8'ha4, 8'hb2, 8'hb0, 8'hbc};
	int nbs [6] = '{3, 2, 5, 4, 3, 2};
	logic [39:0] notes [$];
	int err_count, checks, len, n;

	audio_play_command_decoder #(.SIL_UNIT_CYCLES(UNIT)) dut (.mclk, .rst_b, .clkEn, .avAddress, .avRead,
		.avWrite, .avWriteData, .avReadData, .avWaitrequest, .spiSclk, .spiCsB, .spiMosi, .spiMiso, .spiMisoOe,
		.poweredDownFlag, .memoryPathBusyFlag, .intLine, .playValid, .playKind, .playIndex, .playLoops,
		.playChan, .playTake, .playDone, .stopPulse, .stopMask, .commandFinishedIrq, .commandErrorIrq);
	spi_host_model host (.mclk, .spiSclk, .spiCsB, .spiMosi, .spiMiso);

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic got(input logic [39:0] v);
		check(v, (notes.size() != 0) ? notes.pop_front() : 40'h0);
	endtask
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic idle(input int k);
		repeat (k) @(posedge mclk);
	endtask
	// request held until waitrequest is seen low at a rising edge; read data taken at that edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		avAddress <= a;
		avWriteData <= d;
		avWrite <= wr;
		avRead <= !wr;
		@(posedge mclk);
		while (avWaitrequest !== 1'b0) begin
			@(posedge mclk);
		end
		q = avReadData;
		avRead <= 1'b0;
		avWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check({8'h0, q}, {8'h0, e});
	endtask
	task automatic frame(input logic [39:0] d, input int nb);
		host.sendFrame(d, nb, st);
	endtask
	// engine side: take the offer after a random stall
	task automatic start(input logic [7:0] op, input logic [31:0] arg, input int nb, input cmd_kind_t k,
		input logic [1:0] c);
		int w;
		w = 0;
		if (nb > 0)
			frame({op, arg}, nb);
		notes.push_back({4'h3, k, c, ix, lp});
		while (playValid !== 1'b1 && w < 200) begin
			w++;
			@(negedge mclk);
		end
		if (w >= 200) begin
			err_count++;
		end
		idle($urandom_range(1, 4));
		playTake <= 1'b1;
		@(posedge mclk);
		playTake <= 1'b0;
	endtask
	task automatic finish(input logic [1:0] c);
		notes.push_back(FIN);
		idle(2);
		playDone <= 3'b001 << c;
		@(posedge mclk);
		playDone <= 3'b000;
		idle(4);
	endtask
	task automatic stop(input logic [2:0] m);
		stopSeen = 3'b000;
		frame(40'h2a00000000, 1);
		check({37'h0, stopSeen}, {37'h0, m});
	endtask

	always @(negedge mclk) begin
		if (rst_b === 1'b1 && commandFinishedIrq === 1'b1)
			got(FIN);
		if (rst_b === 1'b1 && commandErrorIrq === 1'b1)
			got(ERR);
		if (playValid === 1'b1 && playTake === 1'b1)
			got({4'h3, playKind, playChan, playIndex, playLoops});
		if (stopPulse === 1'b1)
			stopSeen = stopMask;
	end

	initial begin
		idle(60000);
		err_count++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_b = 1'b0;
		clkEn = 1'b1;
		{avAddress, avRead, avWrite, avWriteData} = '0;
		{poweredDownFlag, memoryPathBusyFlag, intLine, playTake, playDone} = '0;
		{err_count, checks, stopSeen, lp} = '0;
		void'($urandom(55187));
		idle(5);
		rst_b <= 1'b1;
		idle(3);
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h40);
		bus(1'b1, 8'h04, 32'hff);
		rd(8'h04, 32'h40);
		rd(8'h3c, 32'h0);
		intLine <= 1'b1;
		idle(2);
		rd(8'h04, 32'h60);
		intLine <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd(8'h10 + 8'(4 * i), 32'h0);
			idxVal[i] = 16'($urandom());
			bus(1'b1, 8'h10 + 8'(4 * i), {16'h0, idxVal[i]});
			rd(8'h10 + 8'(4 * i), {16'h0, idxVal[i]});
		end
		// every prompt and macro opcode on a random channel
		for (int i = 0; i < 6; i++) begin
			ch = 2'($urandom_range(0, 2));
			bus(1'b1, 8'h00, {30'h0, ch});
			rb = 8'($urandom());
			ix = 16'($urandom());
			lp = (i == 2 || i == 3) ? 16'($urandom_range(1, 65535)) : 16'h1;
			// by-register commands offer the index held in the selected register
			if (i % 2) begin
				ix = idxVal[rb[1:0]];
			end
			start(ops[i], (i % 2) ? {rb, lp, 8'h0} : {ix, lp}, nbs[i], (i >= 4) ? KIND_MACRO : KIND_PROMPT, ch);
			check({32'h0, st}, 40'h40);
			idle($urandom_range(1, 30));
			finish(ch);
		end
		len = $urandom_range(1, 4);
		notes.push_back(FIN);
		frame({8'ha8, 8'(len), 24'h0}, 2);
		n = 0;
		while (commandFinishedIrq !== 1'b1 && n < 400) begin
			n++;
			@(negedge mclk);
		end
		check({39'h0, (n >= len * 64 - 24 && n <= len * 64 + 4)}, 40'h1);
		poweredDownFlag <= 1'b1;
		notes.push_back(ERR);
		frame(40'ha612340000, 3);
		poweredDownFlag <= 1'b0;
		memoryPathBusyFlag <= 1'b1;
		notes.push_back(ERR);
		frame(40'hb000010000, 3);
		memoryPathBusyFlag <= 1'b0;
		// buffer held, then target channel busy
		bus(1'b1, 8'h00, 32'h0);
		ix = 16'($urandom());
		lp = 16'h1;
		frame({8'ha6, ix, 16'h0}, 3);
		rd(8'h04, 32'h02);
		bus(1'b1, 8'h00, 32'h1);
		notes.push_back(ERR);
		frame(40'ha600050000, 3);
		start(8'h00, 32'h0, 0, KIND_PROMPT, 2'd0);
		bus(1'b1, 8'h00, 32'h0);
		notes.push_back(ERR);
		frame(40'ha801000000, 2);
		bus(1'b1, 8'h00, 32'h1);
		ix = 16'($urandom());
		start(8'ha6, {ix, 16'h0}, 3, KIND_PROMPT, 2'd1);
		finish(2'd1);
		bus(1'b1, 8'h00, 32'h0);
		stop(3'b001);
		finish(2'd0);
		// stop flushes a queued command
		bus(1'b1, 8'h00, 32'h2);
		frame(40'ha600070000, 3);
		// nothing runs on channel 2, so the flush alone must not pulse stop
		stop(3'b000);
		check({39'h0, playValid}, 40'h0);
		rd(8'h04, 32'h40);
		// select 3 ignores plays and stops every channel
		bus(1'b1, 8'h00, 32'h1);
		start(8'ha6, {ix, 16'h0}, 3, KIND_PROMPT, 2'd1);
		bus(1'b1, 8'h00, 32'h3);
		frame(40'ha600090000, 3);
		frame(40'ha802000000, 2);
		// only channel 1 runs; the stop mask names running channels only
		stop(3'b010);
		finish(2'd1);
		// stop cuts a long silence short
		bus(1'b1, 8'h00, 32'h0);
		notes.push_back(FIN);
		frame(40'ha8ff000000, 2);
		// silence is timed here, so the engine gets no stop pulse
		stop(3'b000);
		idle(30);
		check(40'(notes.size()), 40'h0);
		// idle stop and short frames leave everything alone
		frame(40'h2a00000000, 1);
		frame(40'ha600000000, 1);
		frame(40'hb000000000, 1);
		frame(40'ha400110000, 3);
		rd(8'h04, 32'h40);
		rd(8'h10, {16'h0, idxVal[0]});
		idle(50);
		check(40'(notes.size()), 40'h0);
		summarize();
	end
endmodule
